// ==== hdl/asf_status_flags.sv ====
// actuator status flags: jam, inhibit, interlocks, thermostat, monitor
// contacts arrive from pins; commands and position are on ref_clk_i
//
// Operation
// - set jammed when at end, commanded to move, no motion before timeout
// - jammed stays set until position moves at least two percent
// - moving inhibited is motion-inhibit timer or interrupter timer active
// - in position control, inhibit timer holds off new motor starts
// - interrupter pulses motion on and off over a stroke band
// - pending network action resumes by itself after inhibit ends
// - open interlock follows contact; gates opening when interlocking on
// - close interlock follows contact; gates closing when interlocking on
// - position control flag true while a positioning command executes
// - thermostat contact open sets thermostat flag and stops motor
// - after thermostat trip, move commands are rejected until reset
// - option lets emergency shutdown override thermostat trip
// - thermostat flag holds until contact resets itself
// - monitor flag set when remote unavailable: local, stop or trip
// - alarm mode: local or local-stop do not set monitor flag
// - loss of any supply phase sets monitor flag
// - not-in-remote true when selector is local or local-stop
`timescale 1ns/100ps
module asf_status_flags
  import asf_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // contacts from pins, asynchronous
  input wire logic oilk_contact_i,
  input wire logic cilk_contact_i,
  input wire logic thermo_ok_i,
  input wire logic sel_remote_i,
  input wire logic sel_lstop_i,
  input wire logic sel_local_i,
  input wire logic at_open_i,
  input wire logic at_close_i,
  input wire logic [2:0] phase_ok_i,
  // commands and position, same clock
  input wire logic net_open_i,
  input wire logic net_close_i,
  input wire logic net_stop_i,
  input wire logic pos_cmd_i,
  input wire logic local_open_i,
  input wire logic local_close_i,
  input wire logic esd_i,
  input wire logic [POS_W-1:0] position_i,
  // set-up
  input wire logic cfg_ilk_en_i,
  input wire logic cfg_esd_ovr_i,
  input wire logic cfg_esd_open_i,
  input wire logic cfg_mon_alarm_i,
  input wire logic cfg_int_en_i,
  input wire logic [POS_W-1:0] cfg_int_lo_i,
  input wire logic [POS_W-1:0] cfg_int_hi_i,
  input wire logic [TMR_W-1:0] cfg_jam_ms_i,
  input wire logic [TMR_W-1:0] cfg_inhibit_ms_i,
  input wire logic [TMR_W-1:0] cfg_int_on_ms_i,
  input wire logic [TMR_W-1:0] cfg_int_off_ms_i,
  // status flags
  output logic jammed_o,
  output logic moving_inh_o,
  output logic open_ilk_o,
  output logic close_ilk_o,
  output logic pos_ctrl_o,
  output logic thermostat_o,
  output logic not_remote_o,
  output logic monitor_o,
  // motor drive
  output logic run_open_o,
  output logic run_close_o
);

  logic [SYNC_W-1:0] s;
  logic [TICK_W-1:0] tick_cnt;
  logic [TICK_W-1:0] next_tick_cnt;
  logic tick;
  logic next_tick;

  asf_tmr_if jam_if ();
  asf_tmr_if mi_if ();
  asf_tmr_if int_if ();

  // every contact passes two flops before use
  asf_sync u_sync (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .raw_i({phase_ok_i, at_close_i, at_open_i, sel_local_i, sel_lstop_i,
            sel_remote_i, thermo_ok_i, cilk_contact_i, oilk_contact_i}),
    .sync_o(s)
  );

  asf_timer u_jam_tmr (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .t(jam_if.timer)
  );

  asf_timer u_mi_tmr (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .t(mi_if.timer)
  );

  asf_timer u_int_tmr (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .t(int_if.timer)
  );

  // millisecond tick shared by all timers
  always_comb begin
    next_tick = 1'b0;
    next_tick_cnt = tick_cnt + 1'b1;
    if (tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
      next_tick_cnt = '0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
    end
  end

  // contact flags
  logic phase_lost;
  logic next_oilk;
  logic next_cilk;
  logic next_thermo;
  logic next_not_remote;
  logic next_phase_lost;
  logic next_monitor;
  logic next_pos_ctrl;

  // flags follow the synchronised contacts; pos_ctrl_o follows pos_cmd_i
  always_comb begin
    next_oilk = s[SI_OILK];
    next_cilk = s[SI_CILK];
    next_thermo = !s[SI_THERMO]; // open contact is a trip
    next_not_remote = s[SI_LOCAL] | s[SI_LSTOP];
    next_phase_lost = !(&s[SI_PH2:SI_PH0]);
    next_monitor = next_thermo | next_phase_lost
                 | (next_not_remote & !cfg_mon_alarm_i);
    next_pos_ctrl = pos_cmd_i;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      open_ilk_o <= 1'b0;
      close_ilk_o <= 1'b0;
      thermostat_o <= 1'b0;
      not_remote_o <= 1'b0;
      phase_lost <= 1'b0;
      monitor_o <= 1'b0;
      pos_ctrl_o <= 1'b0;
    end else begin
      open_ilk_o <= next_oilk;
      close_ilk_o <= next_cilk;
      thermostat_o <= next_thermo;
      not_remote_o <= next_not_remote;
      phase_lost <= next_phase_lost;
      monitor_o <= next_monitor;
      pos_ctrl_o <= next_pos_ctrl;
    end
  end

  // command handling
  logic pend_open;
  logic pend_close;
  logic next_pend_open;
  logic next_pend_close;
  logic remote_ok;
  logic thermo_block;
  logic want_open;
  logic want_close;

  // network commands only count in remote with no thermal trip
  assign remote_ok = s[SI_REMOTE] & !thermostat_o;
  assign thermo_block = thermostat_o & !(esd_i & cfg_esd_ovr_i);

  // a pending network action survives an inhibit, no resend needed
  always_comb begin
    next_pend_open = pend_open;
    next_pend_close = pend_close;
    if (!remote_ok || net_stop_i) begin
      next_pend_open = 1'b0;
      next_pend_close = 1'b0;
    end else if (net_open_i) begin
      next_pend_open = 1'b1;
      next_pend_close = 1'b0;
    end else if (net_close_i) begin
      next_pend_open = 1'b0;
      next_pend_close = 1'b1;
    end
    if (s[SI_AT_OPEN]) begin
      next_pend_open = 1'b0;
    end
    if (s[SI_AT_CLOSE]) begin
      next_pend_close = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_open <= 1'b0;
      pend_close <= 1'b0;
    end else begin
      pend_open <= next_pend_open;
      pend_close <= next_pend_close;
    end
  end

  // demand: emergency first, then remote, then local selector
  always_comb begin
    want_open = 1'b0;
    want_close = 1'b0;
    if (esd_i) begin
      want_open = cfg_esd_open_i;
      want_close = !cfg_esd_open_i;
    end else if (s[SI_REMOTE]) begin
      want_open = pend_open;
      want_close = pend_close;
    end else if (s[SI_LOCAL]) begin
      want_open = local_open_i & !local_close_i;
      want_close = local_close_i & !local_open_i;
    end
  end

  // interrupter pulsing
  asf_int_e int_st;
  asf_int_e next_int_st;
  logic in_band;
  logic demand;

  assign in_band = (position_i >= cfg_int_lo_i) &&
                   (position_i <= cfg_int_hi_i);
  assign demand = (want_open | want_close) & !esd_i;

  // on and off phases alternate while the band and demand last
  always_comb begin
    next_int_st = int_st;
    int_if.start = 1'b0;
    int_if.clr = 1'b0;
    int_if.load = cfg_int_on_ms_i;
    unique case (int_st)
      INT_IDLE: begin
        if (cfg_int_en_i && in_band && demand) begin
          next_int_st = INT_ON;
          int_if.start = 1'b1;
        end
      end
      INT_ON: begin
        if (!(cfg_int_en_i && in_band && demand)) begin
          next_int_st = INT_IDLE;
          int_if.clr = 1'b1;
        end else if (int_if.done) begin
          next_int_st = INT_OFF;
          int_if.start = 1'b1;
          int_if.load = cfg_int_off_ms_i;
        end
      end
      INT_OFF: begin
        if (int_if.done) begin
          next_int_st = (cfg_int_en_i && in_band && demand) ? INT_ON
                                                            : INT_IDLE;
          int_if.start = (next_int_st == INT_ON);
        end
      end
      default: begin
        next_int_st = INT_IDLE;
        int_if.clr = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      int_st <= INT_IDLE;
    end else begin
      int_st <= next_int_st;
    end
  end

  // motor drive and motion inhibit
  logic next_run_open;
  logic next_run_close;
  logic hold_off;
  logic next_mov_inh;

  // esd bypasses the hold-off so a trip-out is never delayed
  assign hold_off = (mi_if.busy | (int_st == INT_OFF)) & !esd_i;

  always_comb begin
    next_run_open = want_open & !thermo_block & !s[SI_AT_OPEN]
                  & !(cfg_ilk_en_i & !open_ilk_o & !esd_i)
                  & !hold_off;
    next_run_close = want_close & !thermo_block & !s[SI_AT_CLOSE]
                   & !(cfg_ilk_en_i & !close_ilk_o & !esd_i)
                   & !hold_off;
    next_mov_inh = mi_if.busy | (next_int_st != INT_IDLE);
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_open_o <= 1'b0;
      run_close_o <= 1'b0;
      moving_inh_o <= 1'b0;
    end else begin
      run_open_o <= next_run_open;
      run_close_o <= next_run_close;
      moving_inh_o <= next_mov_inh;
    end
  end

  // a stop in position control arms the start hold-off
  always_comb begin
    mi_if.tick = tick;
    mi_if.clr = esd_i;
    mi_if.load = cfg_inhibit_ms_i;
    mi_if.start = (run_open_o | run_close_o) & !next_run_open
                & !next_run_close & pos_ctrl_o & (int_st != INT_OFF);
    int_if.tick = tick;
    jam_if.tick = tick;
  end

  // jam supervision
  logic [POS_W-1:0] jam_ref;
  logic [POS_W-1:0] next_jam_ref;
  logic next_jammed;
  logic moved;
  logic at_end;
  logic net_cmd;

  assign at_end = s[SI_AT_OPEN] | s[SI_AT_CLOSE];
  assign net_cmd = (net_open_i | net_close_i) & remote_ok;
  assign moved = (asf_absdiff(position_i, jam_ref) >= MOVE_DELTA);

  // timer runs from a command at end of travel until motion is seen
  always_comb begin
    jam_if.start = net_cmd & at_end & !jam_if.busy;
    jam_if.clr = jam_if.busy & moved;
    jam_if.load = cfg_jam_ms_i;
    next_jam_ref = jam_ref;
    if (jam_if.start) begin
      next_jam_ref = position_i;
    end
    // set beats clear; release needs two percent of travel
    next_jammed = jam_if.done | (jammed_o &
                  (asf_absdiff(position_i, jam_ref) < JAM_CLR_DELTA));
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      jam_ref <= '0;
      jammed_o <= 1'b0;
    end else begin
      jam_ref <= next_jam_ref;
      jammed_o <= next_jammed;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  AST_JAM_SET: assert property (jam_if.done |=> jammed_o)
    else $error("jam timeout did not set jammed flag");
  AST_JAM_HOLD: assert property (
    jammed_o && (asf_absdiff(position_i, jam_ref) < JAM_CLR_DELTA)
    |=> jammed_o)
    else $error("jammed flag dropped before two percent of travel");
  AST_JAM_CLR: assert property (
    jam_if.busy && moved |=> !jam_if.busy)
    else $error("jam timer not cleared by movement");
  AST_MOV_INH: assert property (
    mi_if.busy |=> moving_inh_o)
    else $error("moving inhibited not set during inhibit timer");
  AST_HOLD_OFF: assert property (
    mi_if.busy && !esd_i && !run_open_o |=> !run_open_o)
    else $error("motor started during motion inhibit");
  AST_OPEN_ILK: assert property (
    cfg_ilk_en_i && !open_ilk_o && !esd_i |=> !run_open_o)
    else $error("opened without interlock permission");
  AST_CLOSE_ILK: assert property (
    cfg_ilk_en_i && !close_ilk_o && !esd_i |=> !run_close_o)
    else $error("closed without interlock permission");
  AST_THERMO_STOP: assert property (
    thermostat_o && !esd_i |=> !run_open_o && !run_close_o)
    else $error("motor ran with thermostat tripped");
  AST_MON_THERMO: assert property (thermostat_o |-> monitor_o)
    else $error("thermostat trip missing from monitor flag");
  AST_MON_PHASE: assert property (phase_lost |-> monitor_o)
    else $error("phase loss missing from monitor flag");
  AST_POS_CTRL: assert property (
    pos_cmd_i ##1 pos_cmd_i |-> pos_ctrl_o)
    else $error("position control flag missing");

endmodule : asf_status_flags

// ==== common/asf_pkg.sv ====
// constants, state codes and helpers for the actuator status flag block
// assumes a single system clock; positions come in tenths of a percent
package asf_pkg;

  // clock and timer base
  localparam int CLK_PERIOD_PS = 8000;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYC = TICK_TIME_US * 1000 * 1000 / CLK_PERIOD_PS;
  localparam int TICK_W = 17;
  localparam int TMR_W = 16;

  // position scale: 10'h3e8 is full travel
  localparam int POS_W = 10;
  localparam logic [POS_W-1:0] POS_FULL = 10'h3e8;
  localparam logic [POS_W-1:0] JAM_CLR_DELTA = 10'h014;
  localparam logic [POS_W-1:0] MOVE_DELTA = 10'h001;

  // synchronised contact bits
  localparam int SYNC_W = 11;
  localparam int SI_OILK = 0;
  localparam int SI_CILK = 1;
  localparam int SI_THERMO = 2;
  localparam int SI_REMOTE = 3;
  localparam int SI_LSTOP = 4;
  localparam int SI_LOCAL = 5;
  localparam int SI_AT_OPEN = 6;
  localparam int SI_AT_CLOSE = 7;
  localparam int SI_PH0 = 8;
  localparam int SI_PH2 = 10;
  // idle level of each contact, so a reset release shows no false trip
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 11'h704;

  // interrupter pulse states
  typedef enum logic [2:0] {
    INT_IDLE = 3'h1,
    INT_ON = 3'h2,
    INT_OFF = 3'h4
  } asf_int_e;

  // distance between two positions
  function automatic logic [POS_W-1:0] asf_absdiff(
    input logic [POS_W-1:0] a,
    input logic [POS_W-1:0] b
  );
    asf_absdiff = (a >= b) ? (a - b) : (b - a);
  endfunction : asf_absdiff

endpackage : asf_pkg

// ==== common/asf_tmr_if.sv ====
// control and status of one millisecond countdown timer
// the owner drives tick, start, clear and load; the timer answers
`timescale 1ns/100ps
interface asf_tmr_if;
  import asf_pkg::*;
  logic tick;
  logic start;
  logic clr;
  logic [TMR_W-1:0] load;
  logic busy;
  logic done;
  modport owner (output tick, start, clr, load, input busy, done);
  modport timer (input tick, start, clr, load, output busy, done);
endinterface : asf_tmr_if

// ==== hdl/asf_sync.sv ====
// two-flop synchroniser for a bundle of contact inputs
// inputs may change at any time relative to ref_clk_i
`timescale 1ns/100ps
module asf_sync
  import asf_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // raw and synchronised bits
  input wire logic [SYNC_W-1:0] raw_i,
  output logic [SYNC_W-1:0] sync_o
);

  logic [SYNC_W-1:0] meta;
  logic [SYNC_W-1:0] stable;

  // the first stage feeds only the second stage; both reset to the idle
  // level so the thermostat and phase flags do not pulse after reset
  for (genvar g = 0; g < SYNC_W; g++) begin : g_bit
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        meta[g] <= SYNC_IDLE[g];
        stable[g] <= SYNC_IDLE[g];
      end else begin
        meta[g] <= raw_i[g];
        stable[g] <= meta[g];
      end
    end
  end

  assign sync_o = stable;

endmodule : asf_sync

// ==== hdl/asf_timer.sv ====
// millisecond countdown timer; start loads, clear aborts
// tick is a one-cycle pulse once per millisecond from the owner
`timescale 1ns/100ps
module asf_timer
  import asf_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // control from the owner
  asf_tmr_if.timer t
);

  logic [TMR_W-1:0] count;
  logic [TMR_W-1:0] next_count;
  logic done;
  logic next_done;

  // clear beats start, start beats counting
  always_comb begin
    next_count = count;
    next_done = 1'b0;
    if (t.clr) begin
      next_count = '0;
    end else if (t.start) begin
      next_count = t.load;
    end else if (t.tick && (count != '0)) begin
      next_count = count - 1'b1;
      next_done = (count == {{(TMR_W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count <= '0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      done <= next_done;
    end
  end

  assign t.busy = (count != '0);
  assign t.done = done;

endmodule : asf_timer

// ==== bench/asf_host_model.sv ====
// fieldbus host model: sends one-cycle network command pulses
// assumes the testbench asks for commands between clock edges
`timescale 1ns/100ps
module asf_host_model (
  // clock
  input wire logic ref_clk_i,
  // command pulses to the block
  output logic net_open_o,
  output logic net_close_o,
  output logic net_stop_o
);
  // quiet until asked
  initial begin
    {net_stop_o, net_close_o, net_open_o} = 3'h0;
  end

  // one pulse per request, never repeated while inhibited
  task automatic send(input logic [2:0] cmd);
    @(negedge ref_clk_i);
    {net_stop_o, net_close_o, net_open_o} = cmd;
    @(negedge ref_clk_i);
    {net_stop_o, net_close_o, net_open_o} = 3'h0;
  endtask : send
endmodule : asf_host_model

// ==== bench/testbench.sv ====
// self-checking bench for the actuator status flag block
// assumes a shortened millisecond tick so timers finish quickly
`timescale 1ns/100ps
module testbench;
  import asf_pkg::*;
  // flag vector bit masks, jammed down to run_close
  localparam logic [9:0] M_JAM = 10'h200, M_INH = 10'h100, M_ILK = 10'h0c0;
  localparam logic [9:0] M_POS = 10'h020, M_TH = 10'h010, M_NR = 10'h008;
  localparam logic [9:0] M_MON = 10'h004, M_RO = 10'h002;
  logic ref_clk_i = 1'b0;
  logic resetn_i, oilk, cilk, thermo_ok, sel_rem, sel_lstop, sel_loc;
  logic at_open, at_close, net_open, net_close, net_stop, pos_cmd;
  logic loc_open, loc_close, esd, ilk_en, esd_ovr, esd_open, mon_alarm;
  logic [2:0] phase_ok;
  logic [POS_W-1:0] position;
  logic int_en;
  logic [POS_W-1:0] int_lo, int_hi;
  logic [TMR_W-1:0] jam_ms, inh_ms, int_on, int_off;
  wire logic [9:0] flags;
  logic [19:0] notes[$];
  event sample_ev;
  int error_cnt = 0;
  int n_checks = 0;
  int seed = 32'h99c0fdff;

  // tick shortened to 4 cycles to keep timer waits small
  asf_status_flags #(.TICK_CYCLES(4)) i_dut (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .oilk_contact_i(oilk), .cilk_contact_i(cilk), .thermo_ok_i(thermo_ok),
    .sel_remote_i(sel_rem), .sel_lstop_i(sel_lstop), .sel_local_i(sel_loc),
    .at_open_i(at_open), .at_close_i(at_close), .phase_ok_i(phase_ok),
    .net_open_i(net_open), .net_close_i(net_close), .net_stop_i(net_stop),
    .pos_cmd_i(pos_cmd), .local_open_i(loc_open), .local_close_i(loc_close),
    .esd_i(esd), .position_i(position), .cfg_ilk_en_i(ilk_en),
    .cfg_esd_ovr_i(esd_ovr), .cfg_esd_open_i(esd_open),
    .cfg_mon_alarm_i(mon_alarm), .cfg_int_en_i(int_en),
    .cfg_int_lo_i(int_lo), .cfg_int_hi_i(int_hi),
    .cfg_jam_ms_i(jam_ms), .cfg_inhibit_ms_i(inh_ms),
    .cfg_int_on_ms_i(int_on), .cfg_int_off_ms_i(int_off),
    .jammed_o(flags[9]), .moving_inh_o(flags[8]), .open_ilk_o(flags[7]),
    .close_ilk_o(flags[6]), .pos_ctrl_o(flags[5]), .thermostat_o(flags[4]),
    .not_remote_o(flags[3]), .monitor_o(flags[2]), .run_open_o(flags[1]),
    .run_close_o(flags[0])
  );

  asf_host_model i_host (
    .ref_clk_i(ref_clk_i), .net_open_o(net_open),
    .net_close_o(net_close), .net_stop_o(net_stop)
  );

  // 125 MHz clock
  initial begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  task automatic wcyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : wcyc

  // note the expectation; every caller waits a clock before the next note
  task automatic expect_flags(input logic [9:0] m, input logic [9:0] e);
    notes.push_back({m, e});
    -> sample_ev;
  endtask : expect_flags

  task automatic cmp_flags(input logic [9:0] m, input logic [9:0] e);
    n_checks++;
    if ((flags & m) !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, flags & m, e);
    end
  endtask : cmp_flags

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // monitor: oldest note against the outputs as they stand
  initial begin
    logic [19:0] n;
    forever begin
      @(sample_ev);
      n = notes.pop_front();
      cmp_flags(n[19:10], n[9:0]);
    end
  end

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    error_cnt++;
    finish_test();
  end

  initial begin
    {resetn_i, oilk, cilk, sel_lstop, sel_loc, at_open, at_close} = 7'h0;
    {pos_cmd, loc_open, loc_close, esd, ilk_en, esd_ovr} = 6'h0;
    {esd_open, mon_alarm, thermo_ok, sel_rem, phase_ok} = 7'h1f;
    position = 10'h1f4;
    {int_en, int_lo, int_hi} = {1'b0, 10'h000, POS_FULL};
    {jam_ms, inh_ms} = {16'h0003, 16'h0005};
    {int_on, int_off} = {16'h0001, 16'h0008};
    wcyc(2);
    expect_flags(10'h3ff, 10'h000);
    wcyc(2);
    resetn_i = 1'b1;
    $display("test reset done");
    // random contacts; the flags just follow them
    for (int i = 0; i < 8; i++) begin
      {oilk, cilk} = 2'($random(seed));
      wcyc(4);
      expect_flags(M_ILK, {2'h0, oilk, cilk, 6'h0});
    end
    $display("test contacts done");
    // local stop and local, in both monitor modes
    for (int i = 0; i < 4; i++) begin
      mon_alarm = i[1];
      {sel_rem, sel_loc, sel_lstop} = {1'b0, i[0], ~i[0]};
      {loc_open, loc_close} = {~i[1], i[1]};
      wcyc(5);
      expect_flags(M_NR | M_MON | M_RO | 10'h1, M_NR | (i[1] ? 10'h0 : M_MON)
        | (i[0] ? (i[1] ? 10'h1 : M_RO) : 10'h0));
    end
    {sel_rem, sel_loc, sel_lstop, loc_open, loc_close, mon_alarm} = 6'h20;
    wcyc(5);
    expect_flags(M_NR | M_MON, 10'h0);
    for (int p = 0; p < 3; p++) begin
      phase_ok = ~(3'h1 << p);
      wcyc(4);
      expect_flags(M_MON, M_MON);
    end
    phase_ok = 3'h7;
    $display("test monitor done");
    // interlocks gate network moves when enabled
    ilk_en = 1'b1;
    for (int d = 0; d < 2; d++) begin
      for (int g = 0; g < 2; g++) begin
        {oilk, cilk} = g[0] ? 2'h3 : 2'h0;
        wcyc(4);
        i_host.send(3'h1 << d);
        wcyc(3);
        expect_flags(M_RO >> d, g[0] ? (M_RO >> d) : 10'h0);
        i_host.send(3'h4);
      end
    end
    ilk_en = 1'b0;
    $display("test interlock done");
    // thermostat trip, then the emergency override
    thermo_ok = 1'b0;
    wcyc(4);
    expect_flags(M_TH | M_MON, M_TH | M_MON);
    i_host.send(3'h1);
    wcyc(3);
    expect_flags(M_RO, 10'h0);
    for (int o = 0; o < 4; o++) begin
      {esd, esd_ovr, esd_open} = {1'b1, o[1], o[0]};
      wcyc(3);
      expect_flags(M_RO | 10'h1,
        o[1] ? (o[0] ? M_RO : 10'h1) : 10'h0);
    end
    {esd, thermo_ok} = 2'h1;
    wcyc(4);
    expect_flags(M_TH | M_MON, 10'h0);
    i_host.send(3'h4);
    $display("test thermostat done");
    // jam at the closed limit, released by a 2 percent move only
    {at_close, position} = {1'b1, 10'h000};
    wcyc(4);
    i_host.send(3'h1);
    wcyc(40);
    expect_flags(M_JAM, M_JAM);
    position = 10'h013;
    wcyc(3);
    expect_flags(M_JAM, M_JAM);
    position = 10'h014;
    wcyc(3);
    expect_flags(M_JAM, 10'h0);
    i_host.send(3'h4);
    {at_close, position} = {1'b0, 10'h1f4};
    $display("test jam done");
    // inhibit after a positioning stop; pending open resumes alone
    pos_cmd = 1'b1;
    wcyc(2);
    expect_flags(M_POS, M_POS);
    i_host.send(3'h1);
    wcyc(3);
    expect_flags(M_RO, M_RO);
    i_host.send(3'h4);
    wcyc(3);
    expect_flags(M_INH | M_RO, M_INH);
    i_host.send(3'h1);
    wcyc(3);
    expect_flags(M_RO, 10'h0);
    wcyc(40);
    expect_flags(M_INH | M_RO, M_RO);
    i_host.send(3'h4);
    pos_cmd = 1'b0;
    wcyc(2);
    expect_flags(M_POS, 10'h0);
    $display("test inhibit done");
    // interrupter over the whole stroke: one tick on, eight ticks off
    int_en = 1'b1;
    wcyc(30);
    i_host.send(3'h1);
    wcyc(2);
    expect_flags(M_INH | M_RO, M_INH | M_RO);
    wcyc(11);
    expect_flags(M_INH | M_RO, M_INH);
    i_host.send(3'h4);
    wcyc(40);
    expect_flags(M_INH | M_RO, 10'h0);
    int_en = 1'b0;
    $display("test interrupter done");
    wcyc(1);
    finish_test();
  end
endmodule : testbench
